// ==== rtl/tcc_pkg.sv ====
// tcc_pkg: shared constants for the timer compare/capture general registers.
// assumes: one core clock, counters and io control registers live outside this block.
package tcc_pkg;
    // =====================================================================
    // sizes
    localparam int          NUM_CH     = 5;
    localparam int          GR_W       = 16;
    localparam int          ADDR_W     = 4;
    localparam int          NUM_GR     = 2 * NUM_CH;
    localparam logic [15:0] GR_RESET   = 16'hffff;
    // =====================================================================
    // register index: addr[3:1] selects the channel, addr[0] selects a or b
    localparam int          ADDR_SEL_B = 0;
    localparam int          ADDR_CH_LO = 1;
    // =====================================================================
    // io control field (3 bits per register)
    localparam int          IO_CAP_BIT = 2;
    localparam logic [2:0]  IO_NONE    = 3'h0;
    localparam logic [1:0]  OUT_NONE   = 2'h0;
    localparam logic [1:0]  OUT_LOW    = 2'h1;
    localparam logic [1:0]  OUT_HIGH   = 2'h2;
    localparam logic [1:0]  OUT_TOGGLE = 2'h3;
    localparam logic [1:0]  EDGE_RISE  = 2'h0;
    localparam logic [1:0]  EDGE_FALL  = 2'h1;
    // =====================================================================
    // counter clear source per channel
    localparam logic [1:0]  CLR_NONE   = 2'h0;
    localparam logic [1:0]  CLR_BY_A   = 2'h1;
    localparam logic [1:0]  CLR_BY_B   = 2'h2;
endpackage

// ==== rtl/tcc_unit.sv ====
// tcc_unit: one general register with its compare, capture and pin logic.
// assumes: count and count_tick come from the channel counter in the core clock domain.
`timescale 1ns/100ps
module tcc_unit #(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic         standby,
    input  wire logic [2:0]   io_ctrl,
    input  wire logic         pwm_mode,
    input  wire logic [W-1:0] count,
    input  wire logic         count_tick,
    input  wire logic         cap_in,
    input  wire logic         wr_en,
    input  wire logic [1:0]   wr_be,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] value,
    output logic              evt,
    output logic              pin_out,
    output logic              pin_oe_n
);
    typedef struct packed {
        logic [W-1:0] value;
        logic         cap_prev;
        logic         pin;
        logic         oe_n;
    } tcc_unit_st_t;

    localparam tcc_unit_st_t RST = '{value: W'(tcc_pkg::GR_RESET), cap_prev: 1'b0,
                                     pin: 1'b0, oe_n: 1'b1};

    tcc_unit_st_t s_ff;
    tcc_unit_st_t nxt_s;

    always_comb begin
        logic [2:0] eff;
        logic       is_cap;
        logic       rise;
        logic       fall;
        logic       hit;
        hit    = 1'b0;
        // event leaves combinationally so the flag lands with the stored value
        evt    = 1'b0;
        eff    = (pwm_mode || standby) ? tcc_pkg::IO_NONE : io_ctrl;
        is_cap = eff[tcc_pkg::IO_CAP_BIT];
        rise   = cap_in && !s_ff.cap_prev;
        fall   = !cap_in && s_ff.cap_prev;
        case (eff[1:0])
            tcc_pkg::EDGE_RISE: hit = rise;
            tcc_pkg::EDGE_FALL: hit = fall;
            default:            hit = rise || fall;
        endcase
        nxt_s          = s_ff;
        nxt_s.cap_prev = cap_in;
        if (standby) begin
            nxt_s = RST;
            // keep tracking the pin, else a high pin gives a false edge after standby
            nxt_s.cap_prev = cap_in;
        end else begin
            if (wr_en && wr_be[0]) begin
                nxt_s.value[7:0] = wr_data[7:0];
            end
            if (wr_en && wr_be[1]) begin
                nxt_s.value[W-1:8] = wr_data[W-1:8];
            end
            if (is_cap) begin
                if (hit) begin
                    nxt_s.value = count;
                    evt         = 1'b1;
                end
            end else if (count_tick && s_ff.value == count) begin
                evt       = 1'b1;
                case (eff[1:0])
                    tcc_pkg::OUT_LOW:    nxt_s.pin = 1'b0;
                    tcc_pkg::OUT_HIGH:   nxt_s.pin = 1'b1;
                    tcc_pkg::OUT_TOGGLE: nxt_s.pin = !s_ff.pin;
                    default:             nxt_s.pin = s_ff.pin;
                endcase
            end
            // pin is only driven in compare mode with an output selected
            nxt_s.oe_n = is_cap || (eff[1:0] == tcc_pkg::OUT_NONE);
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign value    = s_ff.value;
    assign pin_out  = s_ff.pin;
    assign pin_oe_n = s_ff.oe_n;
endmodule

// ==== rtl/tcc_top.sv ====
// tcc_top: the ten compare/capture general registers of the five timer channels,
// their status flags, counter clear requests and the 16-bit cpu access port.
// assumes: counters, io control and mode registers sit outside; all inputs synchronous.
//
// Notes on behaviour
// - five channels, two 16-bit registers each
// - io control picks compare or capture
// - compare mode: register compared with count
// - compare match sets channel a/b flag
// - enabled output drives configured pin level
// - capture mode: edge stores count value
// - capture sets flag with the store
// - capture edge rising, falling or both
// - pwm modes override io control selection
// - cpu word read, word or byte write
// - reset/standby: compare mode, no pin
// - reset/standby: registers load all ones
// - optional counter clear on a/b event
`timescale 1ns/100ps
module tcc_top #(
    parameter int NUM_CH = tcc_pkg::NUM_CH,
    parameter int W      = tcc_pkg::GR_W
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                standby,
    input  wire logic [NUM_CH*W-1:0] count,
    input  wire logic [NUM_CH-1:0]   count_tick,
    input  wire logic [NUM_CH*3-1:0] io_ctrl_a,
    input  wire logic [NUM_CH*3-1:0] io_ctrl_b,
    input  wire logic [NUM_CH-1:0]   pwm_mode,
    input  wire logic [NUM_CH*2-1:0] clear_sel,
    input  wire logic [NUM_CH-1:0]   cap_pin_a,
    input  wire logic [NUM_CH-1:0]   cap_pin_b,
    input  wire logic [NUM_CH-1:0]   flag_clr_a,
    input  wire logic [NUM_CH-1:0]   flag_clr_b,
    input  wire logic                cpu_wr,
    input  wire logic                cpu_rd,
    input  wire logic [tcc_pkg::ADDR_W-1:0] cpu_addr,
    input  wire logic [1:0]          cpu_be,
    input  wire logic [W-1:0]        cpu_wdata,
    output logic      [W-1:0]        cpu_rdata,
    output logic      [NUM_CH-1:0]   match_flag_a,
    output logic      [NUM_CH-1:0]   match_flag_b,
    output logic      [NUM_CH-1:0]   count_clear,
    output logic      [NUM_CH-1:0]   cmp_pin_a,
    output logic      [NUM_CH-1:0]   cmp_pin_b,
    output logic      [NUM_CH-1:0]   cmp_oe_a_n,
    output logic      [NUM_CH-1:0]   cmp_oe_b_n
);
    // =====================================================================
    // state
    typedef struct packed {
        logic [NUM_CH-1:0] flag_a;
        logic [NUM_CH-1:0] flag_b;
        logic [NUM_CH-1:0] clr;
        logic [W-1:0]      rdata;
    } tcc_top_st_t;

    localparam tcc_top_st_t RST = '{flag_a: '0, flag_b: '0, clr: '0, rdata: '0};

    tcc_top_st_t s_ff;
    tcc_top_st_t nxt_s;

    logic [W-1:0]        gr_val [2*NUM_CH];
    logic [2*NUM_CH-1:0] gr_evt;
    logic [2*NUM_CH-1:0] gr_pin;
    logic [2*NUM_CH-1:0] gr_oe_n;

    // register index from channel and a/b select
    function automatic logic [tcc_pkg::ADDR_W-1:0] tcc_index(input int ch, input int sel_b);
        return tcc_pkg::ADDR_W'((ch << tcc_pkg::ADDR_CH_LO) | (sel_b << tcc_pkg::ADDR_SEL_B));
    endfunction

    // =====================================================================
    // general registers, a then b per channel
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        for (genvar b = 0; b < 2; b++) begin : g_ab
            localparam int IDX = 2 * c + b;
            tcc_unit #(
                .W(W)
            ) u_gr (
                .core_clk   (core_clk),
                .rstn       (rstn),
                .standby    (standby),
                .io_ctrl    ((b == 0) ? io_ctrl_a[3*c +: 3] : io_ctrl_b[3*c +: 3]),
                .pwm_mode   (pwm_mode[c]),
                .count      (count[W*c +: W]),
                .count_tick (count_tick[c]),
                .cap_in     ((b == 0) ? cap_pin_a[c] : cap_pin_b[c]),
                .wr_en      (cpu_wr && cpu_addr == tcc_index(c, b)),
                .wr_be      (cpu_be),
                .wr_data    (cpu_wdata),
                .value      (gr_val[IDX]),
                .evt        (gr_evt[IDX]),
                .pin_out    (gr_pin[IDX]),
                .pin_oe_n   (gr_oe_n[IDX])
            );
        end
        // pins come straight from the unit flip-flops, sorted into a and b here
        assign cmp_pin_a[c]  = gr_pin[2*c];
        assign cmp_pin_b[c]  = gr_pin[2*c+1];
        assign cmp_oe_a_n[c] = gr_oe_n[2*c];
        assign cmp_oe_b_n[c] = gr_oe_n[2*c+1];
    end

    // =====================================================================
    // flags, counter clear, read data
    always_comb begin
        nxt_s       = s_ff;
        nxt_s.rdata = s_ff.rdata;
        for (int c = 0; c < NUM_CH; c++) begin
            // a new event beats a clear in the same cycle
            nxt_s.flag_a[c] = (s_ff.flag_a[c] && !flag_clr_a[c]) || gr_evt[2*c];
            nxt_s.flag_b[c] = (s_ff.flag_b[c] && !flag_clr_b[c]) || gr_evt[2*c+1];
            case (clear_sel[2*c +: 2])
                tcc_pkg::CLR_BY_A: nxt_s.clr[c] = gr_evt[2*c];
                tcc_pkg::CLR_BY_B: nxt_s.clr[c] = gr_evt[2*c+1];
                default:           nxt_s.clr[c] = 1'b0;
            endcase
        end
        if (cpu_rd) begin
            nxt_s.rdata = '0;
            for (int i = 0; i < 2 * NUM_CH; i++) begin
                if (cpu_addr == tcc_index(i / 2, i % 2)) begin
                    nxt_s.rdata = gr_val[i];
                end
            end
        end
        if (standby) begin
            nxt_s = RST;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign cpu_rdata    = s_ff.rdata;
    assign match_flag_a = s_ff.flag_a;
    assign match_flag_b = s_ff.flag_b;
    assign count_clear  = s_ff.clr;
endmodule

// ==== test/tcc_sva.sv ====
// tcc_sva: port checks on tcc_top, channel 0 register a standing for all.
// assumes: bound from the bench onto tcc_top.
`timescale 1ns/100ps
module tcc_sva #(parameter int NUM_CH = 5, parameter int W = 16) (
    input wire logic                       core_clk,
    input wire logic                       rstn,
    input wire logic                       standby,
    input wire logic [NUM_CH-1:0]          count_tick,
    input wire logic [NUM_CH*3-1:0]        io_ctrl_a,
    input wire logic [NUM_CH-1:0]          pwm_mode,
    input wire logic [NUM_CH*2-1:0]        clear_sel,
    input wire logic [NUM_CH-1:0]          cap_pin_a,
    input wire logic [NUM_CH-1:0]          flag_clr_a,
    input wire logic                       cpu_rd,
    input wire logic [tcc_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic [W-1:0]               cpu_rdata,
    input wire logic [NUM_CH-1:0]          match_flag_a,
    input wire logic [NUM_CH-1:0]          count_clear,
    input wire logic [NUM_CH-1:0]          cmp_pin_a,
    input wire logic [NUM_CH-1:0]          cmp_oe_a_n
);
    // ====================
    // checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    AST_FLAG_CAUSE: assert property ($rose(match_flag_a[0]) |->
        $past(count_tick[0]) || $past(cap_pin_a[0]) != $past(cap_pin_a[0], 2))
        else $error("flag set without cause");
    AST_FLAG_HOLD: assert property (match_flag_a[0] && !flag_clr_a[0] && !standby
        |=> match_flag_a[0]) else $error("flag dropped without clear");
    AST_SBY: assert property (standby |=>
        !match_flag_a[0] && cmp_oe_a_n[0] && !cmp_pin_a[0]) else $error("standby state wrong");
    AST_OE_CAP: assert property (io_ctrl_a[2] [*2] |-> cmp_oe_a_n[0])
        else $error("pin driven in capture mode");
    AST_OE_PWM: assert property (pwm_mode[0] [*2] |-> cmp_oe_a_n[0])
        else $error("pin driven in pwm mode");
    AST_CLR_SRC: assert property (count_clear[0] |->
        $past(clear_sel[1:0]) inside {2'h1, 2'h2}) else $error("clear without source");
    AST_RD_MAP: assert property (cpu_rd && cpu_addr >= 4'ha |=>
        cpu_rdata == 16'h0) else $error("unmapped read not zero");
    AST_PIN_RISE: assert property ($rose(cmp_pin_a[0]) |->
        $past(count_tick[0]) && $past(io_ctrl_a[1])) else $error("pin rose without match");
    cover property ($rose(match_flag_a[0]) && !$past(count_tick[0]));
    cover property (count_clear[0]);
    cover property ($rose(cmp_pin_a[0]));
endmodule

// ==== test/tcc_cnt_model.sv ====
// tcc_cnt_model: the five channel counters facing the registers.
// assumes: one count per clock while run is high; count_clear restarts at zero.
`timescale 1ns/100ps
module tcc_cnt_model (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [4:0]  run,
    input  wire logic [4:0]  count_clear,
    output logic      [79:0] count,
    output logic      [4:0]  count_tick
);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count      <= '0;
            count_tick <= '0;
        end else begin
            // tick marks the cycle in which the new count is shown
            count_tick <= run | count_clear;
            for (int c = 0; c < 5; c++) begin
                if (count_clear[c]) count[16*c+:16] <= 16'h0;
                else if (run[c]) count[16*c+:16] <= count[16*c+:16] + 16'h1;
            end
        end
    end
endmodule

// ==== test/tcc_top_bench.sv ====
// tcc_top_bench: directed checks of the general registers, mostly channel 0 a.
// assumes: tcc_pkg compiled first; counters come from tcc_cnt_model.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tcc_top_bench;
    logic        core_clk = 0, rstn = 0, standby = 0, cpu_wr = 0, cpu_rd = 0;
    logic [4:0]  run = '0, pwm = '0, cap_a = '0, fclr_a = '0, fclr_b = '0;
    logic [14:0] io_a     = '0, io_b = '0;
    logic [9:0]  clr_sel  = '0;
    logic [3:0]  cpu_addr = '0;
    logic [1:0]  cpu_be   = '0;
    logic [15:0] cpu_wdata = '0, cpu_rdata, rv;
    logic [79:0] count;
    logic [4:0]  count_tick, count_clear, flag_a, pin_a, oe_a_n, flag_b, pin_b, oe_b_n;
    int          n_mismatch = 0, samples_checked = 0;
    tcc_top u_tcc_top (.core_clk(core_clk), .rstn(rstn), .standby(standby), .count(count),
        .count_tick(count_tick), .io_ctrl_a(io_a), .io_ctrl_b(io_b), .pwm_mode(pwm),
        .clear_sel(clr_sel), .cap_pin_a(cap_a), .cap_pin_b(5'h0), .flag_clr_a(fclr_a),
        .flag_clr_b(fclr_b), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .cpu_be(cpu_be), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .match_flag_a(flag_a),
        .match_flag_b(flag_b), .count_clear(count_clear), .cmp_pin_a(pin_a), .cmp_pin_b(pin_b),
        .cmp_oe_a_n(oe_a_n), .cmp_oe_b_n(oe_b_n));
    tcc_cnt_model u_tcc_cnt_model (.core_clk(core_clk), .rstn(rstn), .run(run),
        .count_clear(count_clear), .count(count), .count_tick(count_tick));
    initial forever #5 core_clk = ~core_clk;
    // ====================
    // bus cycles and closing
    task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge core_clk);
        {cpu_wr, cpu_addr, cpu_be, cpu_wdata} = {1'b1, a, be, d};
        @(negedge core_clk);
        cpu_wr = 0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(negedge core_clk);
        {cpu_rd, cpu_addr} = {1'b1, a};
        @(negedge core_clk);
        cpu_rd = 0;
        rv = cpu_rdata;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ====================
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < 10; i++) begin
            rd(i[3:0]);
            `CHK(rv, tcc_pkg::GR_RESET)
        end
        `CHK({oe_a_n, oe_b_n}, 10'h3ff)
    endtask
    task automatic t_bytes;
        wr(4'h3, 2'h3, 16'h1234);
        wr(4'h3, 2'h1, 16'hffab);
        wr(4'h3, 2'h2, 16'hcdff);
        rd(4'h3);
        `CHK(rv, 16'hcdab)
        wr(4'hc, 2'h3, 16'h0);
        rd(4'hc);
        `CHK(rv, 16'h0)
    endtask
    task automatic t_compare;
        wr(4'h0, 2'h3, 16'h0020);
        io_a[2:0] = {1'b0, tcc_pkg::OUT_HIGH};
        clr_sel[1:0] = tcc_pkg::CLR_BY_A;
        run[0] = 1;
        for (int i = 0; i < 100 && flag_a[0] !== 1'b1; i++) @(negedge core_clk);
        `CHK(flag_a[0], 1'b1)
        if (flag_a[0] !== 1'b1) give_verdict();
        `CHK({pin_a[0], oe_a_n[0], count_clear[0]}, 3'h5)
        run[0] = 0;
        fclr_a[0] = 1;
        @(negedge core_clk);
        fclr_a[0] = 0;
        `CHK(flag_a[0], 1'b0)
    endtask
    task automatic t_compare_b;
        wr(4'h1, 2'h3, 16'h0008);
        io_b[2:0] = {1'b0, tcc_pkg::OUT_TOGGLE};
        clr_sel[1:0] = tcc_pkg::CLR_BY_B;
        run[0] = 1;
        for (int i = 0; i < 100 && flag_b[0] !== 1'b1; i++) @(negedge core_clk);
        `CHK({flag_b[0], pin_b[0], oe_b_n[0], count_clear[0]}, 4'hd)
        if (flag_b[0] !== 1'b1) give_verdict();
        // the b match restarted the counter, so the next match toggles the pin back
        for (int i = 0; i < 100 && pin_b[0] !== 1'b0; i++) @(negedge core_clk);
        `CHK(pin_b[0], 1'b0)
        if (pin_b[0] !== 1'b0) give_verdict();
        run[0] = 0;
        fclr_b[0] = 1;
        @(negedge core_clk);
        fclr_b[0] = 0;
        `CHK(flag_b[0], 1'b0)
    endtask
    task automatic t_capture;
        logic [15:0] c;
        run[0] = 1;
        for (int e = 0; e < 3; e++) begin
            io_a[2:0] = {1'b1, e[1:0]};
            for (int lv = 1; lv >= 0; lv--) begin
                fclr_a[0] = 1;
                @(negedge core_clk);
                {fclr_a[0], cap_a[0]} = {1'b0, lv[0]};
                c = count[15:0];
                @(negedge core_clk);
                `CHK(flag_a[0], lv ? (e != 1) : (e != 0))
                if (flag_a[0] === 1'b1) begin
                    rd(4'h0);
                    `CHK(rv, c)
                end
            end
        end
    endtask
    task automatic t_standby;
        standby = 1;
        @(negedge core_clk);
        `CHK({flag_a[0], oe_a_n[0], flag_b[0], oe_b_n[0], pin_b[0]}, 5'h0a)
        {standby, pwm[0], cap_a[0]} = 3'h3;
        repeat (3) @(negedge core_clk);
        `CHK(flag_a[0], 1'b0)
        rd(4'h0);
        `CHK(rv, tcc_pkg::GR_RESET)
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        rstn = 1;
        t_reset();
        t_bytes();
        t_compare();
        t_compare_b();
        t_capture();
        t_standby();
        give_verdict();
    end
endmodule
bind tcc_top tcc_sva #(.NUM_CH(NUM_CH), .W(W)) u_tcc_sva (.core_clk(core_clk), .rstn(rstn),
    .standby(standby), .count_tick(count_tick), .io_ctrl_a(io_ctrl_a), .pwm_mode(pwm_mode),
    .clear_sel(clear_sel), .cap_pin_a(cap_pin_a), .flag_clr_a(flag_clr_a), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .match_flag_a(match_flag_a),
    .count_clear(count_clear), .cmp_pin_a(cmp_pin_a), .cmp_oe_a_n(cmp_oe_a_n));
